// ---- etc_cfg.svh ----
`ifndef ETC_CFG_SVH
`define ETC_CFG_SVH
// register byte offsets
`define ETC_OFF_CTRL 8'h00
`define ETC_OFF_COUNT 8'h01
`define ETC_OFF_CMP 8'h02
`define ETC_OFF_FLAG 8'h03
`define ETC_OFF_MASK 8'h04
// control register fields
`define ETC_CS_LSB 0
`define ETC_CS_MSB 2
`define ETC_WGM0_BIT 3
`define ETC_WGM1_BIT 6
`define ETC_COM_LSB 4
`define ETC_COM_MSB 5
`define ETC_FOC_BIT 7
// flag / mask fields
`define ETC_OVF_BIT 0
`define ETC_CMF_BIT 1
// reset value, count limits and synchroniser depth
`define ETC_RST_BYTE 8'h00
`define ETC_BOTTOM 8'h00
`define ETC_MAX 8'hFF
`define ETC_EXT_SYNC 2
`endif

// ---- etc_pkg.sv ----
package etc_pkg;
  typedef enum logic [1:0] {ETC_NORMAL, ETC_PWM_PC, ETC_CTC, ETC_PWM_FAST} etc_mode_e;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } etc_req_s;
  // flags served by the interrupt unit
  typedef struct packed {
    logic ovf;
    logic cmp;
  } etc_ack_s;
  typedef logic [7:0] etc_byte_t;
endpackage

// ---- etc_timer.sv ----
`timescale 1ns/1ps
`include "etc_cfg.svh"
// Overview of operation
// - count and compare are 8-bit read/write registers
// - each flag in flag reg, gated by mask
// - tick from prescaler or external count pin
// - clock select picks source and edge
// - select zero stops counter, value held
// - continuous compare sets compare-match flag
// - compare register is double buffered
// - match drives waveform on compare output pin
// - bottom indication when count becomes 0x00
// - max recognised when count becomes 0xFF
// - top is 0xFF or compare value
// - counter counts up/down by one, clears
// - each tick clears, increments or decrements
// - count readable/writable without any tick
// - software count write beats tick update
// - waveform mode bits set count sequence
// - overflow flag set per mode, requests interrupt
// - match flag set next tick; clear by ack/one
// - count write blocks matches next tick
// - buffering only in pwm modes, else direct
// - normal mode wraps, overflow when zero
module etc_timer #(
  parameter int PRESC_W = 10
) (
  // clock and reset
  input wire logic refClk,
  input wire logic nrst,
  // register port
  input wire etc_pkg::etc_req_s busReq,
  output logic [7:0] busRdata,
  // interrupt unit
  input wire etc_pkg::etc_ack_s irqAck,
  output logic ovfIrq,
  output logic cmpIrq,
  // pins
  input wire logic externalCountPin,
  output logic compareOutputPin,
  // status
  output logic bottomInd,
  output logic topInd,
  output logic maxInd
);
  import etc_pkg::*;

  // the /1024 tap needs ten prescaler bits
  if (PRESC_W < 10 || PRESC_W > 16) begin : g_presc_chk
    $error("etc_timer: PRESC_W must be 10..16");
  end

  // request decode used by several processes
  function automatic logic hit(input etc_req_s r, input logic [7:0] off, input logic isWr);
    hit = (isWr ? r.wr : r.rd) && (r.addr == off);
  endfunction

  logic [7:0] ctrl_ff;
  logic [7:0] count_ff;
  logic [7:0] cmpBuf_ff;
  logic [7:0] cmpAct_ff;
  logic [1:0] flag_ff;
  logic [1:0] mask_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic [`ETC_EXT_SYNC-1:0] extSync_ff;
  logic extLast_ff;
  logic dirDown_ff;
  logic blockMatch_ff;
  logic matchSeen_ff;
  logic [7:0] busRdata_ff;
  logic ocOut_ff;
  logic ovfIrq_ff;
  logic cmpIrq_ff;
  logic bottom_ff;
  logic top_ff;
  logic max_ff;
  logic [2:0] clkSel;
  logic [1:0] com;
  etc_mode_e mode;
  logic tick;
  logic isPwm;
  logic [7:0] topVal;
  logic cntWr;
  logic [7:0] nxt_count;
  logic nxt_dirDown;
  logic ovfSet;
  logic match;
  logic foc;
  logic [1:0] flagSet;
  logic [1:0] flagClr;

  assign clkSel = ctrl_ff[`ETC_CS_MSB:`ETC_CS_LSB];
  assign com = ctrl_ff[`ETC_COM_MSB:`ETC_COM_LSB];
  assign mode = etc_mode_e'({ctrl_ff[`ETC_WGM1_BIT], ctrl_ff[`ETC_WGM0_BIT]});
  assign isPwm = (mode == ETC_PWM_PC) || (mode == ETC_PWM_FAST);
  assign topVal = (mode == ETC_CTC) ? cmpAct_ff : `ETC_MAX;
  assign cntWr = hit(busReq, `ETC_OFF_COUNT, 1'b1);
  assign foc = hit(busReq, `ETC_OFF_CTRL, 1'b1) && busReq.wdata[`ETC_FOC_BIT] && !isPwm;
  assign match = (count_ff == cmpAct_ff);

  // prescaler free-runs; external pin synchronised before edge detect
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      presc_ff <= '0;
      extSync_ff <= '0;
      extLast_ff <= 1'b0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
      extSync_ff <= {extSync_ff[`ETC_EXT_SYNC-2:0], externalCountPin};
      extLast_ff <= extSync_ff[`ETC_EXT_SYNC-1];
    end
  end

  // tick source and edge selection; taps at /8,/64,/256,/1024
  always_comb begin
    case (clkSel)
      3'd0: tick = 1'b0;
      3'd1: tick = 1'b1;
      3'd2: tick = &presc_ff[2:0];
      3'd3: tick = &presc_ff[5:0];
      3'd4: tick = &presc_ff[7:0];
      3'd5: tick = &presc_ff[9:0];
      3'd6: tick = extLast_ff && !extSync_ff[`ETC_EXT_SYNC-1];
      3'd7: tick = !extLast_ff && extSync_ff[`ETC_EXT_SYNC-1];
      default: tick = 1'b0;
    endcase
  end

  // next count per mode; phase correct turns at top and bottom
  always_comb begin
    nxt_count = count_ff;
    nxt_dirDown = dirDown_ff;
    ovfSet = 1'b0;
    case (mode)
      ETC_NORMAL, ETC_PWM_FAST: begin
        nxt_count = count_ff + 8'h01;
        nxt_dirDown = 1'b0;
        ovfSet = (count_ff == `ETC_MAX);
      end
      ETC_CTC: begin
        nxt_count = (count_ff == topVal) ? `ETC_BOTTOM : count_ff + 8'h01;
        nxt_dirDown = 1'b0;
        ovfSet = (count_ff == `ETC_MAX);
      end
      ETC_PWM_PC: begin
        if (dirDown_ff) begin
          nxt_count = count_ff - 8'h01;
          if (count_ff == 8'h01) begin
            nxt_dirDown = 1'b0;
          end
        end else begin
          nxt_count = count_ff + 8'h01;
          if (count_ff == 8'h FE) begin
            nxt_dirDown = 1'b1;
          end
        end
        // overflow on the tick that brings the down count to bottom
        ovfSet = dirDown_ff && (count_ff == 8'h01);
      end
      default: begin
        nxt_count = count_ff;
      end
    endcase
  end

  // control, mask and count registers
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= `ETC_RST_BYTE;
      mask_ff <= 2'b00;
      count_ff <= `ETC_RST_BYTE;
      dirDown_ff <= 1'b0;
    end else begin
      if (hit(busReq, `ETC_OFF_CTRL, 1'b1)) begin
        ctrl_ff <= {1'b0, busReq.wdata[6:0]}; // force strobe never stored
      end
      if (hit(busReq, `ETC_OFF_MASK, 1'b1)) begin
        mask_ff <= busReq.wdata[1:0];
      end
      if (cntWr) begin
        count_ff <= busReq.wdata;
      end else if (tick) begin
        count_ff <= nxt_count;
        dirDown_ff <= nxt_dirDown;
      end
    end
  end

  // compare buffer: direct in non-pwm, loaded on the tick at top (0xFF) in pwm
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      cmpBuf_ff <= `ETC_RST_BYTE;
      cmpAct_ff <= `ETC_RST_BYTE;
    end else begin
      if (hit(busReq, `ETC_OFF_CMP, 1'b1)) begin
        cmpBuf_ff <= busReq.wdata;
      end
      if (!isPwm) begin
        cmpAct_ff <= hit(busReq, `ETC_OFF_CMP, 1'b1) ? busReq.wdata : cmpBuf_ff;
      end else if (tick && (mode == ETC_PWM_FAST ? count_ff == `ETC_MAX : count_ff == `ETC_MAX)) begin
        cmpAct_ff <= cmpBuf_ff; // update at top
      end
    end
  end

  // match sampled, flag set on following tick; count write blocks one tick
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      blockMatch_ff <= 1'b0;
      matchSeen_ff <= 1'b0;
    end else begin
      if (cntWr) begin
        blockMatch_ff <= 1'b1;
      end else if (tick) begin
        blockMatch_ff <= 1'b0;
      end
      // a write also drops a pending match, so no stale flag lands after it
      if (cntWr) begin
        matchSeen_ff <= 1'b0;
      end else if (tick) begin
        matchSeen_ff <= match && !blockMatch_ff;
      end
    end
  end

  // set and clear requests per flag bit
  assign flagSet[`ETC_OVF_BIT] = tick && ovfSet && !cntWr;
  assign flagSet[`ETC_CMF_BIT] = tick && matchSeen_ff;
  assign flagClr[`ETC_OVF_BIT] = irqAck.ovf || (hit(busReq, `ETC_OFF_FLAG, 1'b1) && busReq.wdata[`ETC_OVF_BIT]);
  assign flagClr[`ETC_CMF_BIT] = irqAck.cmp || (hit(busReq, `ETC_OFF_FLAG, 1'b1) && busReq.wdata[`ETC_CMF_BIT]);

  // flags: hardware set wins over software or ack clear
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (flagSet[i]) begin
          flag_ff[i] <= 1'b1;
        end else if (flagClr[i]) begin
          flag_ff[i] <= 1'b0;
        end
      end
    end
  end

  // waveform generator: non-pwm com 1 toggle, 2 clear, 3 set; pwm com 2 sets at bottom, com 3 clears
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      ocOut_ff <= 1'b0;
    end else if ((tick && matchSeen_ff) || foc) begin
      if (isPwm) begin
        // com zero leaves the pin alone in pwm as well
        if (com[1]) begin
          ocOut_ff <= com[0];
        end
      end else begin
        case (com)
          2'd1: ocOut_ff <= !ocOut_ff;
          2'd2: ocOut_ff <= 1'b0;
          2'd3: ocOut_ff <= 1'b1;
          default: ocOut_ff <= ocOut_ff;
        endcase
      end
    end else if (isPwm && tick && count_ff == `ETC_BOTTOM && com[1]) begin
      ocOut_ff <= !com[0];
    end
  end

  // registered outputs and read data
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      busRdata_ff <= 8'h00;
      ovfIrq_ff <= 1'b0;
      cmpIrq_ff <= 1'b0;
      bottom_ff <= 1'b0;
      top_ff <= 1'b0;
      max_ff <= 1'b0;
    end else begin
      busRdata_ff <= 8'h00;
      if (busReq.rd) begin
        case (busReq.addr)
          `ETC_OFF_CTRL: busRdata_ff <= ctrl_ff;
          `ETC_OFF_COUNT: busRdata_ff <= count_ff;
          `ETC_OFF_CMP: busRdata_ff <= cmpBuf_ff;
          `ETC_OFF_FLAG: busRdata_ff <= {6'd0, flag_ff};
          `ETC_OFF_MASK: busRdata_ff <= {6'd0, mask_ff};
          default: busRdata_ff <= 8'h00;
        endcase
      end
      ovfIrq_ff <= flag_ff[`ETC_OVF_BIT] && mask_ff[`ETC_OVF_BIT];
      cmpIrq_ff <= flag_ff[`ETC_CMF_BIT] && mask_ff[`ETC_CMF_BIT];
      bottom_ff <= (count_ff == `ETC_BOTTOM);
      top_ff <= (count_ff == topVal);
      max_ff <= (count_ff == `ETC_MAX);
    end
  end

  assign busRdata = busRdata_ff;
  assign ovfIrq = ovfIrq_ff;
  assign cmpIrq = cmpIrq_ff;
  assign compareOutputPin = ocOut_ff;
  assign bottomInd = bottom_ff;
  assign topInd = top_ff;
  assign maxInd = max_ff;

  chk_stop_holds: assert property (@(posedge refClk) disable iff (!nrst)
    (clkSel == 3'd0 && !cntWr) |=> $stable(count_ff)) else $error("count moved while stopped");
  chk_write_wins: assert property (@(posedge refClk) disable iff (!nrst)
    cntWr |=> count_ff == $past(busReq.wdata)) else $error("count write lost");
  chk_ovf_normal: assert property (@(posedge refClk) disable iff (!nrst)
    (tick && !cntWr && mode == ETC_NORMAL && count_ff == 8'hFF) |=> count_ff == 8'h00 && flag_ff[0])
    else $error("normal wrap missing overflow");
  chk_block_write: assert property (@(posedge refClk) disable iff (!nrst)
    cntWr |=> !matchSeen_ff) else $error("match not blocked after write");
  chk_irq_gate: assert property (@(posedge refClk) disable iff (!nrst)
    ##1 cmpIrq == $past(flag_ff[1] && mask_ff[1])) else $error("irq gating wrong");
  chk_bottom_ind: assert property (@(posedge refClk) disable iff (!nrst)
    count_ff == 8'h00 |=> bottomInd) else $error("bottom missing");
  chk_max_ind: assert property (@(posedge refClk) disable iff (!nrst)
    count_ff == 8'hFF |=> maxInd) else $error("max missing");
  chk_cmf_set: assert property (@(posedge refClk) disable iff (!nrst)
    (tick && matchSeen_ff) |=> flag_ff[1]) else $error("compare flag not set");
  chk_direct_cmp: assert property (@(posedge refClk) disable iff (!nrst)
    (!isPwm && hit(busReq, 8'h02, 1'b1)) |=> cmpAct_ff == $past(busReq.wdata)) else $error("direct compare failed");
  chk_pc_ovf: assert property (@(posedge refClk) disable iff (!nrst)
    (tick && !cntWr && mode == ETC_PWM_PC && dirDown_ff && count_ff == 8'h01) |=> count_ff == 8'h00 && flag_ff[0])
    else $error("phase correct overflow missing");
  chk_pwm_hold: assert property (@(posedge refClk) disable iff (!nrst)
    (isPwm && !(tick && count_ff == 8'hFF)) |=> $stable(cmpAct_ff)) else $error("buffered compare moved early");
  cov_wrap: cover property (@(posedge refClk) disable iff (!nrst) tick && count_ff == 8'hFF);
  cov_match: cover property (@(posedge refClk) disable iff (!nrst) tick && matchSeen_ff);
  cov_pc_turn: cover property (@(posedge refClk) disable iff (!nrst) mode == ETC_PWM_PC && dirDown_ff);
  cov_fast_bottom: cover property (@(posedge refClk) disable iff (!nrst) mode == ETC_PWM_FAST && tick && count_ff == 8'h00);
endmodule

// ---- etc_cpu_model.sv ----
`timescale 1ns/1ps
// register-bus master and pin driver standing in for the cpu core
module etc_cpu_model (
  // clock
  input wire logic refClk,
  // register port
  output etc_pkg::etc_req_s busReq,
  input wire logic [7:0] busRdata,
  // interrupt unit and count pin
  output etc_pkg::etc_ack_s irqAck,
  output logic externalCountPin
);
  import etc_pkg::*;

  // idle levels at time zero
  initial begin
    busReq = '0;
    irqAck = '0;
    externalCountPin = 1'b0;
  end

  // one-cycle write; released data is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge refClk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge refClk);
    busReq.wr <= 1'b0;
    busReq.wdata <= ~d;
  endtask

  // read data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge refClk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge refClk);
    busReq.rd <= 1'b0;
    @(negedge refClk);
    d = busRdata;
  endtask

  // interrupt serviced for the compare request
  task automatic ackCmp();
    @(posedge refClk);
    irqAck.cmp <= 1'b1;
    @(posedge refClk);
    irqAck.cmp <= 1'b0;
  endtask

  // slow pulses, wide enough for the two-stage synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge refClk);
      externalCountPin <= 1'b1;
      repeat (4) @(posedge refClk);
      externalCountPin <= 1'b0;
      repeat (4) @(posedge refClk);
    end
  endtask
endmodule

// ---- tb_etc_timer.sv ----
`timescale 1ns/1ps
`include "etc_cfg.svh"
module tb_etc_timer;
  import etc_pkg::*;
  logic refClk = 1'b0;
  logic nrst = 1'b0;
  etc_req_s busReq;
  etc_ack_s irqAck;
  logic [7:0] busRdata;
  logic ovfIrq, cmpIrq, externalCountPin, compareOutputPin, bottomInd, topInd, maxInd;
  logic [5:0] obs;
  logic [7:0] d, e;
  int num_errors = 0;
  int total_checks = 0;

  // watched outputs, indexed by wait_hi
  assign obs = {bottomInd, compareOutputPin, topInd, maxInd, cmpIrq, ovfIrq};
  // 25 MHz
  always #20 refClk = ~refClk;

  etc_timer DUT (.refClk(refClk), .nrst(nrst), .busReq(busReq), .busRdata(busRdata), .irqAck(irqAck),
    .ovfIrq(ovfIrq), .cmpIrq(cmpIrq), .externalCountPin(externalCountPin),
    .compareOutputPin(compareOutputPin), .bottomInd(bottomInd), .topInd(topInd), .maxInd(maxInd));
  etc_cpu_model cpu (.refClk(refClk), .busReq(busReq), .busRdata(busRdata), .irqAck(irqAck),
    .externalCountPin(externalCountPin));

  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // read a register and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    cpu.rd(a, v);
    chk(v, exp);
  endtask

  // bounded wait for a watched output, sampled mid-cycle; running out ends the run
  task automatic wait_hi(input int s, input int lim);
    int i;
    @(negedge refClk);
    for (i = 0; i < lim && obs[s] !== 1'b1; i++) @(negedge refClk);
    chk({7'h00, obs[s]}, 8'h01);
    if (obs[s] !== 1'b1) print_verdict();
  endtask

  task automatic t_reset();
    for (int a = 0; a < 5; a++) rc(a[7:0], `ETC_RST_BYTE);
    rc(8'h10, 8'h00);
    repeat (5) @(posedge refClk);
    rc(`ETC_OFF_COUNT, 8'h00);
    cpu.wr(`ETC_OFF_COUNT, 8'hA5);
    rc(`ETC_OFF_COUNT, 8'hA5);
    cpu.wr(`ETC_OFF_CMP, 8'h5A);
    rc(`ETC_OFF_CMP, 8'h5A);
  endtask

  task automatic t_normal();
    cpu.wr(`ETC_OFF_MASK, 8'h03);
    cpu.wr(`ETC_OFF_COUNT, 8'hFC);
    cpu.wr(`ETC_OFF_CTRL, 8'h01);
    wait_hi(2, 20);
    wait_hi(5, 5);
    wait_hi(0, 5);
    cpu.wr(`ETC_OFF_COUNT, 8'h40);
    cpu.rd(`ETC_OFF_COUNT, d);
    chk({7'h00, d >= 8'h40 && d <= 8'h42}, 8'h01);
    cpu.wr(`ETC_OFF_CTRL, 8'h00);
    rc(`ETC_OFF_FLAG, 8'h01);
    cpu.wr(`ETC_OFF_FLAG, 8'h01);
    rc(`ETC_OFF_FLAG, 8'h00);
  endtask

  task automatic t_match();
    cpu.wr(`ETC_OFF_MASK, 8'h00);
    cpu.wr(`ETC_OFF_CMP, 8'h30);
    cpu.wr(`ETC_OFF_COUNT, 8'h28);
    cpu.wr(`ETC_OFF_CTRL, 8'h01);
    repeat (20) @(posedge refClk);
    cpu.wr(`ETC_OFF_CTRL, 8'h00);
    rc(`ETC_OFF_FLAG, 8'h02);
    chk({7'h00, cmpIrq}, 8'h00);
    cpu.wr(`ETC_OFF_MASK, 8'h02);
    wait_hi(1, 5);
    cpu.ackCmp();
    repeat (3) @(posedge refClk);
    rc(`ETC_OFF_FLAG, 8'h00);
    // counter now parked on the compare value: the first tick must not match
    cpu.wr(`ETC_OFF_COUNT, 8'h30);
    cpu.wr(`ETC_OFF_CTRL, 8'h01);
    repeat (10) @(posedge refClk);
    cpu.wr(`ETC_OFF_CTRL, 8'h00);
    rc(`ETC_OFF_FLAG, 8'h00);
  endtask

  task automatic t_ctc();
    logic p;
    cpu.wr(`ETC_OFF_CMP, 8'h05);
    cpu.wr(`ETC_OFF_COUNT, 8'h00);
    cpu.wr(`ETC_OFF_CTRL, 8'h51);
    wait_hi(3, 20);
    repeat (6) begin
      cpu.rd(`ETC_OFF_COUNT, d);
      chk({7'h00, d <= 8'h05}, 8'h01);
    end
    p = compareOutputPin;
    for (int i = 0; i < 12 && compareOutputPin === p; i++) @(negedge refClk);
    chk({7'h00, compareOutputPin}, {7'h00, ~p});
    // phase-correct mode must turn round at the maximum and count down
    cpu.wr(`ETC_OFF_CTRL, 8'h00);
    cpu.wr(`ETC_OFF_COUNT, 8'hF0);
    cpu.wr(`ETC_OFF_CTRL, 8'h09);
    wait_hi(2, 40);
    cpu.rd(`ETC_OFF_COUNT, d);
    cpu.rd(`ETC_OFF_COUNT, e);
    chk({7'h00, e < d}, 8'h01);
    // jump near bottom while counting down: overflow lands as the count reaches zero
    cpu.wr(`ETC_OFF_FLAG, 8'h03);
    cpu.wr(`ETC_OFF_COUNT, 8'h04);
    repeat (4) @(posedge refClk);
    rc(`ETC_OFF_FLAG, 8'h01);
    cpu.wr(`ETC_OFF_CTRL, 8'h00);
  endtask

  // fast pwm: compare writes wait in the buffer until the count tops out
  task automatic t_fast();
    cpu.wr(`ETC_OFF_FLAG, 8'h03);
    cpu.wr(`ETC_OFF_CMP, 8'h80);
    cpu.wr(`ETC_OFF_COUNT, 8'h00);
    cpu.wr(`ETC_OFF_CTRL, 8'h69);
    cpu.wr(`ETC_OFF_CMP, 8'h08);
    repeat (16) @(posedge refClk);
    rc(`ETC_OFF_FLAG, 8'h00);
    chk({7'h00, compareOutputPin}, 8'h01);
    cpu.wr(`ETC_OFF_MASK, 8'h03);
    wait_hi(0, 300);
    repeat (20) @(posedge refClk);
    rc(`ETC_OFF_FLAG, 8'h03);
    chk({7'h00, compareOutputPin}, 8'h00);
    cpu.wr(`ETC_OFF_CTRL, 8'h00);
  endtask

  task automatic t_source();
    for (int cs = 6; cs < 8; cs++) begin
      cpu.wr(`ETC_OFF_COUNT, 8'h00);
      cpu.wr(`ETC_OFF_CTRL, cs[7:0]);
      cpu.pulses(3);
      repeat (6) @(posedge refClk);
      rc(`ETC_OFF_COUNT, 8'h03);
      cpu.wr(`ETC_OFF_CTRL, 8'h00);
    end
    cpu.pulses(2);
    rc(`ETC_OFF_COUNT, 8'h03);
    // prescaler phase is free running, so allow one tick either way
    cpu.wr(`ETC_OFF_COUNT, 8'h00);
    cpu.wr(`ETC_OFF_CTRL, 8'h02);
    repeat (80) @(posedge refClk);
    cpu.wr(`ETC_OFF_CTRL, 8'h00);
    cpu.rd(`ETC_OFF_COUNT, d);
    chk({7'h00, d >= 8'h09 && d <= 8'h0B}, 8'h01);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge refClk);
    nrst <= 1'b1;
    t_reset();
    t_normal();
    t_match();
    t_ctc();
    t_source();
    t_fast();
    print_verdict();
  end
endmodule
